// ### fpx_cause_decode.sv
// Turns the floating-point unit's raw conditions into a cause vector and a trap decision.
// Assumes the condition inputs are qualified by fp_valid in the same cycle.
`include "fpx_cfg.svh"

module fpx_cause_decode (
  // Carrier towards the status block.
  fpx_cause_if.dec cif,
  // Raw conditions of the finishing operation.
  input wire logic fp_is_div,
  input wire logic fp_divisor_zero,
  input wire logic fp_dividend_nz_finite,
  input wire logic fp_inexact,
  input wire logic fp_underflow,
  input wire logic fp_overflow,
  input wire logic fp_opnd_reserved,
  input wire logic fp_result_reserved,
  input wire logic fp_invalid
);
  import fpx_pkg::*;

  fpx_cause_t det_w;
  fpx_cause_t unmasked_w;

  // ==========================================================================
  // Cause decoding.
  // A zero divided by zero is an invalid operation, not a divide-by-zero.
  assign det_w[`FPX_B_DIV0]    = cif.fp_valid & fp_is_div & fp_divisor_zero
                                 & fp_dividend_nz_finite;
  assign det_w[`FPX_B_INEXACT] = cif.fp_valid & fp_inexact;
  assign det_w[`FPX_B_UNDER]   = cif.fp_valid & fp_underflow;
  assign det_w[`FPX_B_OVER]    = cif.fp_valid & fp_overflow;
  assign det_w[`FPX_B_RESOP]   = cif.fp_valid & (fp_opnd_reserved | fp_result_reserved);
  assign det_w[`FPX_B_INVALID] = cif.fp_valid & fp_invalid;

  // A zero mask enables its trap.
  assign unmasked_w = det_w & ~cif.mask;
  assign cif.det    = det_w;
  assign cif.take   = |unmasked_w;

  // ==========================================================================
  // Checks.
  property p_all_masked_no_trap;
    @(posedge cif.clk) disable iff (!cif.rstn)
    (cif.mask == ~`FPX_CAUSE_RST) |-> !cif.take;
  endproperty
  a_all_masked_no_trap: assert property (p_all_masked_no_trap)
    else $error("Trap raised while every cause is masked.");

  property p_div0_cond;
    @(posedge cif.clk) disable iff (!cif.rstn)
    cif.det[`FPX_B_DIV0] |-> (fp_is_div && fp_divisor_zero && fp_dividend_nz_finite);
  endproperty
  a_div0_cond: assert property (p_div0_cond)
    else $error("Divide-by-zero flagged without a qualifying divide.");

  property p_resop_cond;
    @(posedge cif.clk) disable iff (!cif.rstn)
    (cif.fp_valid && (fp_opnd_reserved || fp_result_reserved)) |-> cif.det[`FPX_B_RESOP];
  endproperty
  a_resop_cond: assert property (p_resop_cond)
    else $error("Reserved operand or result not flagged.");
endmodule

// ### fpx_cause_if.sv
// Carrier between the status block and its cause decoder.
// Assumes both ends share one clock, reset and clock enable.
interface fpx_cause_if (
  input logic clk,
  input logic rstn,
  input logic ce
);
  import fpx_pkg::*;

  logic       fp_valid;
  fpx_cause_t mask;
  fpx_cause_t det;
  logic       take;

  modport dec  (input clk, rstn, ce, fp_valid, mask, output det, take);
  modport core (input det, take, output fp_valid, mask);
endinterface

// ### fpx_cfg.svh
// Constants for the floating-point exception status and trap opcode capture block.
// Assumes inclusion by the package and the design modules; it holds definitions only.
// ==========================================================================
// Notes on behaviour
// - Trap-cause bits change only on a taken trap or a software move.
// - Trap needs one unmasked cause; all causes recorded.
// - A taken trap clears causes not present.
// - Sticky bits hold until a software move clears them.
// - Sticky bit sets only for a masked detected exception or a software move.
// - Masked exceptions still stick when a trap occurs.
// - Cause bits 13..8: div0, inexact, under, over, resop, invalid.
// - Divide-by-zero needs zero divisor, non-zero finite dividend.
// - Reserved operand covers reserved inputs or reserved result.
// - Sticky bits 5..0 in the same order as masks.
// - Trapping opcode loads at write-back into bits 7..0.
// - Non-trapping instructions leave the opcode unchanged.
// - Opcode capture covers every trapping instruction.
// - Status register open to user mode, no violation.
// - Masks sit in environment bits 5..0; zero enables.
// - Status register is special register 162.
`ifndef FPX_CFG_SVH
`define FPX_CFG_SVH

// ==========================================================================
// Special register numbers.
`define FPX_SPR_ENV      8'ha0
`define FPX_SPR_STAT     8'ha2
`define FPX_SPR_OPC      8'ha4

// ==========================================================================
// Field layout.
`define FPX_WORD_W       32
`define FPX_CAUSE_W      6
`define FPX_TRAP_MSB     13
`define FPX_TRAP_LSB     8
`define FPX_STICKY_MSB   5
`define FPX_STICKY_LSB   0
`define FPX_ENV_W        9
`define FPX_OPC_W        8

// Cause positions, shared by masks, sticky bits and trap-cause bits.
`define FPX_B_DIV0       5
`define FPX_B_INEXACT    4
`define FPX_B_UNDER      3
`define FPX_B_OVER       2
`define FPX_B_RESOP      1
`define FPX_B_INVALID    0

// ==========================================================================
// Reset values.
`define FPX_ENV_RST      9'h03f
`define FPX_CAUSE_RST    6'h00
`define FPX_OPC_RST      8'h00

`endif

// ### fpx_pkg.sv
// Types shared by the exception status block and its cause decoder.
// Assumes fpx_cfg.svh is on the include path.
`include "fpx_cfg.svh"

package fpx_pkg;
  // ========================================================================
  // Types.
  typedef logic [`FPX_CAUSE_W-1:0] fpx_cause_t;
  typedef logic [`FPX_WORD_W-1:0]  fpx_word_t;
  typedef logic [`FPX_ENV_W-1:0]   fpx_env_t;
  typedef enum logic [1:0] {
    FPX_SEL_NONE,
    FPX_SEL_ENV,
    FPX_SEL_STAT,
    FPX_SEL_OPC
  } fpx_sel_e;
endpackage

// ### fpx_status_capture.sv
// Floating-point exception status register, environment masks and trap opcode capture.
// Assumes a special-register move port from the pipeline; all inputs are synchronous.
`include "fpx_cfg.svh"

module fpx_status_capture #(
  parameter int OPC_W = `FPX_OPC_W
) (
  // Clock, reset and clock enable.
  input  wire logic              CLK_SYS,
  input  wire logic              RSTN,
  input  wire logic              CE,
  // Special-register move port.
  input  wire logic              SPR_REQ,
  input  wire logic              SPR_WRITE,
  input  wire logic [7:0]        SPR_NUM,
  input  fpx_pkg::fpx_word_t     SPR_WDATA,
  output fpx_pkg::fpx_word_t     SPR_RDATA_Q,
  output logic                   SPR_ACK_Q,
  output logic                   SPR_HIT_Q,
  // Floating-point completion.
  input  wire logic              FP_VALID,
  input  wire logic              FP_IS_DIV,
  input  wire logic              FP_DIVISOR_ZERO,
  input  wire logic              FP_DIVIDEND_NZ_FINITE,
  input  wire logic              FP_INEXACT,
  input  wire logic              FP_UNDERFLOW,
  input  wire logic              FP_OVERFLOW,
  input  wire logic              FP_OPND_RESERVED,
  input  wire logic              FP_RESULT_RESERVED,
  input  wire logic              FP_INVALID,
  output logic                   FP_TRAP_Q,
  output fpx_pkg::fpx_env_t      FP_ENV_Q,
  // Write-back stage.
  input  wire logic              WB_VALID,
  input  wire logic              WB_EXEC_TRAP,
  input  wire logic [OPC_W-1:0]  WB_OPCODE
);
  import fpx_pkg::*;

  // ==========================================================================
  // Elaboration checks.
  if (OPC_W < 1 || OPC_W > `FPX_WORD_W) begin : g_bad_opc_w
    $error("OPC_W must lie between 1 and the word width.");
  end

  // ==========================================================================
  // Decoding.
  function automatic fpx_sel_e sel_of(input logic [7:0] num);
    unique case (num)
      `FPX_SPR_ENV:  sel_of = FPX_SEL_ENV;
      `FPX_SPR_STAT: sel_of = FPX_SEL_STAT;
      `FPX_SPR_OPC:  sel_of = FPX_SEL_OPC;
      default:       sel_of = FPX_SEL_NONE;
    endcase
  endfunction

  function automatic fpx_word_t pack_status(input fpx_cause_t trap, input fpx_cause_t sticky);
    pack_status = '0;
    pack_status[`FPX_TRAP_MSB:`FPX_TRAP_LSB]     = trap;
    pack_status[`FPX_STICKY_MSB:`FPX_STICKY_LSB] = sticky;
  endfunction

  fpx_env_t         env_q;
  fpx_env_t         env_d;
  fpx_cause_t       trap_flags_q;
  fpx_cause_t       trap_flags_d;
  fpx_cause_t       sticky_q;
  fpx_cause_t       sticky_d;
  logic [OPC_W-1:0] trap_opcode_field_q;
  logic [OPC_W-1:0] trap_opcode_field_d;
  fpx_word_t        rdata_d;

  fpx_sel_e  sel;
  logic      wr_env;
  logic      wr_stat;
  logic      wr_opc;
  logic      rd_req;
  logic      wb_capture;
  fpx_word_t env_word;
  fpx_word_t stat_word;
  fpx_word_t opc_word;
  fpx_cause_t sticky_set;
  fpx_cause_t sw_sticky;

  // No privilege input exists here: these registers are open to user mode.
  assign sel     = sel_of(SPR_NUM);
  assign wr_env  = SPR_REQ & SPR_WRITE & (sel == FPX_SEL_ENV);
  assign wr_stat = SPR_REQ & SPR_WRITE & (sel == FPX_SEL_STAT);
  assign wr_opc  = SPR_REQ & SPR_WRITE & (sel == FPX_SEL_OPC);
  assign rd_req  = SPR_REQ & ~SPR_WRITE;

  // ==========================================================================
  // Cause decoder.
  fpx_cause_if cif (
    .clk  (CLK_SYS),
    .rstn (RSTN),
    .ce   (CE)
  );

  assign cif.fp_valid = FP_VALID;
  assign cif.mask     = env_q[`FPX_STICKY_MSB:`FPX_STICKY_LSB];

  fpx_cause_decode u_dec (
    .cif                   (cif),
    .fp_is_div             (FP_IS_DIV),
    .fp_divisor_zero       (FP_DIVISOR_ZERO),
    .fp_dividend_nz_finite (FP_DIVIDEND_NZ_FINITE),
    .fp_inexact            (FP_INEXACT),
    .fp_underflow          (FP_UNDERFLOW),
    .fp_overflow           (FP_OVERFLOW),
    .fp_opnd_reserved      (FP_OPND_RESERVED),
    .fp_result_reserved    (FP_RESULT_RESERVED),
    .fp_invalid            (FP_INVALID)
  );

  // ==========================================================================
  // Next-state selection.
  // Only the environment's low nine bits exist; writes to the rest are dropped.
  assign env_d = wr_env ? SPR_WDATA[`FPX_ENV_W-1:0] : env_q;

  // A taken trap rewrites the whole group, so absent causes clear.
  assign trap_flags_d = wr_stat  ? SPR_WDATA[`FPX_TRAP_MSB:`FPX_TRAP_LSB]
                      : cif.take ? cif.det
                      : trap_flags_q;

  assign sticky_set = cif.det & cif.mask;
  assign sw_sticky  = wr_stat ? SPR_WDATA[`FPX_STICKY_MSB:`FPX_STICKY_LSB] : sticky_q;

  // A masked detection in the cycle of a software clear still sets its bit, so no masked event is lost.
  for (genvar i = 0; i < `FPX_CAUSE_W; i++) begin : g_sticky
    assign sticky_d[i] = sw_sticky[i] | sticky_set[i];
  end

  // Capture wins over a software write in the same cycle: the trap handler needs it.
  assign wb_capture          = WB_VALID & WB_EXEC_TRAP;
  assign trap_opcode_field_d = wb_capture ? WB_OPCODE
                             : wr_opc     ? SPR_WDATA[OPC_W-1:0]
                             : trap_opcode_field_q;

  // ==========================================================================
  // Read path.
  assign env_word  = fpx_word_t'(env_q);
  assign stat_word = pack_status(trap_flags_q, sticky_q);
  assign opc_word  = fpx_word_t'(trap_opcode_field_q);

  assign rdata_d = !rd_req               ? SPR_RDATA_Q
                 : (sel == FPX_SEL_ENV)  ? env_word
                 : (sel == FPX_SEL_STAT) ? stat_word
                 : (sel == FPX_SEL_OPC)  ? opc_word
                 : '0;

  // ==========================================================================
  // State.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      env_q               <= `FPX_ENV_RST;
      trap_flags_q        <= `FPX_CAUSE_RST;
      sticky_q            <= `FPX_CAUSE_RST;
      trap_opcode_field_q <= OPC_W'(`FPX_OPC_RST);
      SPR_RDATA_Q         <= '0;
      SPR_ACK_Q           <= 1'b0;
      SPR_HIT_Q           <= 1'b0;
      FP_TRAP_Q           <= 1'b0;
    end else if (CE) begin
      env_q               <= env_d;
      trap_flags_q        <= trap_flags_d;
      sticky_q            <= sticky_d;
      trap_opcode_field_q <= trap_opcode_field_d;
      SPR_RDATA_Q         <= rdata_d;
      SPR_ACK_Q           <= SPR_REQ;
      SPR_HIT_Q           <= SPR_REQ & (sel != FPX_SEL_NONE);
      FP_TRAP_Q           <= cif.take;
    end
  end

  assign FP_ENV_Q = env_q;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  property p_trap_stable;
    (CE && !cif.take && !wr_stat) |=> $stable(trap_flags_q);
  endproperty
  a_trap_stable: assert property (p_trap_stable)
    else $error("Trap-cause bits moved without a trap.");

  property p_trap_load;
    (CE && cif.take && !wr_stat) |=> (trap_flags_q == $past(cif.det)) && FP_TRAP_Q;
  endproperty
  a_trap_load: assert property (p_trap_load)
    else $error("Trap-cause bits differ from the trapping operation.");

  property p_trap_needs_unmasked;
    ($past(CE) && FP_TRAP_Q) |-> ($past(cif.det) & ~$past(cif.mask)) != `FPX_CAUSE_RST;
  endproperty
  a_trap_needs_unmasked: assert property (p_trap_needs_unmasked)
    else $error("Trap taken without an unmasked cause.");

  property p_sticky_hold;
    (CE && !wr_stat) |=> ((sticky_q & $past(sticky_q)) == $past(sticky_q));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("Sticky bit dropped without a software write.");

  property p_sticky_cause;
    (CE && !wr_stat) |=>
      ((sticky_q & ~$past(sticky_q) & ~($past(cif.det) & $past(cif.mask))) == `FPX_CAUSE_RST);
  endproperty
  a_sticky_cause: assert property (p_sticky_cause)
    else $error("Sticky bit set without a masked detection.");

  property p_sticky_on_trap;
    (CE && cif.take) |=> ((sticky_q & $past(cif.det & cif.mask)) == $past(cif.det & cif.mask));
  endproperty
  a_sticky_on_trap: assert property (p_sticky_on_trap)
    else $error("Masked exception lost alongside a trap.");

  property p_opc_load;
    (CE && wb_capture) |=> (trap_opcode_field_q == $past(WB_OPCODE));
  endproperty
  a_opc_load: assert property (p_opc_load)
    else $error("Trapping opcode not captured.");

  property p_opc_hold;
    (CE && !wb_capture && !wr_opc) |=> $stable(trap_opcode_field_q);
  endproperty
  a_opc_hold: assert property (p_opc_hold)
    else $error("Opcode changed without a trap or write.");

  property p_stat_read;
    (CE && rd_req && sel == FPX_SEL_STAT) |=> SPR_ACK_Q && SPR_HIT_Q
      && SPR_RDATA_Q[`FPX_WORD_W-1:`FPX_TRAP_MSB+1] == '0
      && SPR_RDATA_Q[`FPX_TRAP_LSB-1:`FPX_STICKY_MSB+1] == '0;
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("Status read returned reserved ones or no answer.");

  property p_sw_wins;
    (CE && wr_stat) |=> (trap_flags_q == $past(SPR_WDATA[`FPX_TRAP_MSB:`FPX_TRAP_LSB]));
  endproperty
  a_sw_wins: assert property (p_sw_wins)
    else $error("Software write to trap-cause bits overridden.");

  // A low clock enable must hold every flop, so a stalled pipeline loses nothing.
  property p_ce_freeze;
    !CE |=> $stable(env_q) && $stable(trap_flags_q) && $stable(sticky_q)
      && $stable(trap_opcode_field_q) && $stable(SPR_RDATA_Q) && $stable(SPR_ACK_Q)
      && $stable(SPR_HIT_Q) && $stable(FP_TRAP_Q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("State moved while the clock enable was low.");

  property p_trap_only_when_taken;
    (CE && !cif.take) |=> !FP_TRAP_Q;
  endproperty
  a_trap_only_when_taken: assert property (p_trap_only_when_taken)
    else $error("Trap pulse without a taken trap.");

  property p_ack_every_request;
    CE |=> (SPR_ACK_Q == $past(SPR_REQ));
  endproperty
  a_ack_every_request: assert property (p_ack_every_request)
    else $error("Register access not answered in the next cycle.");

  property p_hit_decode;
    (CE && SPR_REQ) |=> (SPR_HIT_Q == ($past(sel) != FPX_SEL_NONE));
  endproperty
  a_hit_decode: assert property (p_hit_decode)
    else $error("Hit flag disagrees with the register number.");

  property p_env_write;
    (CE && wr_env) |=> (FP_ENV_Q == $past(SPR_WDATA[`FPX_ENV_W-1:0]));
  endproperty
  a_env_write: assert property (p_env_write)
    else $error("Environment write not taken.");

  property p_env_read;
    (CE && rd_req && sel == FPX_SEL_ENV) |=>
      (SPR_RDATA_Q == fpx_word_t'($past(env_q)));
  endproperty
  a_env_read: assert property (p_env_read)
    else $error("Environment read returned wrong or reserved bits.");

  // The read path is checked field by field, so a swapped group shows up here.
  property p_stat_fields;
    (CE && rd_req && sel == FPX_SEL_STAT) |=>
      (SPR_RDATA_Q[`FPX_TRAP_MSB:`FPX_TRAP_LSB] == $past(trap_flags_q))
      && (SPR_RDATA_Q[`FPX_STICKY_MSB:`FPX_STICKY_LSB] == $past(sticky_q));
  endproperty
  a_stat_fields: assert property (p_stat_fields)
    else $error("Status read placed a group in the wrong bits.");

  property p_opc_read;
    (CE && rd_req && sel == FPX_SEL_OPC) |=>
      (SPR_RDATA_Q == fpx_word_t'($past(trap_opcode_field_q)));
  endproperty
  a_opc_read: assert property (p_opc_read)
    else $error("Opcode read returned wrong or reserved bits.");

  property p_unmapped_read;
    (CE && rd_req && sel == FPX_SEL_NONE) |=> !SPR_HIT_Q && (SPR_RDATA_Q == '0);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read hit or returned data.");

  // A masked detection in the write cycle must survive in the sticky bits, or it could vanish.
  property p_sticky_sw_write;
    (CE && wr_stat) |=>
      (sticky_q == ($past(SPR_WDATA[`FPX_STICKY_MSB:`FPX_STICKY_LSB]) | $past(sticky_set)));
  endproperty
  a_sticky_sw_write: assert property (p_sticky_sw_write)
    else $error("Sticky bits differ from the software write.");
endmodule

// ### fpx_tb.sv
// Self-checking bench for the floating-point exception status and trap opcode capture block.
// Assumes fpx_cfg.svh, fpx_pkg.sv, fpx_cause_if.sv, fpx_cause_decode.sv and
// fpx_status_capture.sv are compiled first.
`include "fpx_cfg.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fpx_pkg::*;

  // ==========================================================================
  // Stimulus and observed signals.
  logic           clk_sys;
  logic           rstn;
  logic           ce;
  logic           spr_req;
  logic           spr_write;
  logic [7:0]     spr_num;
  fpx_word_t      spr_wdata;
  fpx_word_t      spr_rdata_q;
  logic           spr_ack_q;
  logic           spr_hit_q;
  logic           fp_valid;
  logic [8:0]     fp_raw;
  logic           fp_trap_q;
  fpx_env_t       fp_env_q;
  logic           wb_valid;
  logic           wb_exec_trap;
  logic [7:0]     wb_opcode;
  int             fail_count;
  int             tests_run;
  fpx_word_t      rd;
  logic           hit;

  fpx_status_capture #(.OPC_W(8)) i_dut (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce),
    .SPR_REQ(spr_req), .SPR_WRITE(spr_write), .SPR_NUM(spr_num), .SPR_WDATA(spr_wdata),
    .SPR_RDATA_Q(spr_rdata_q), .SPR_ACK_Q(spr_ack_q), .SPR_HIT_Q(spr_hit_q),
    .FP_VALID(fp_valid), .FP_IS_DIV(fp_raw[8]), .FP_DIVISOR_ZERO(fp_raw[7]),
    .FP_DIVIDEND_NZ_FINITE(fp_raw[6]), .FP_INEXACT(fp_raw[5]), .FP_UNDERFLOW(fp_raw[4]),
    .FP_OVERFLOW(fp_raw[3]), .FP_OPND_RESERVED(fp_raw[2]), .FP_RESULT_RESERVED(fp_raw[1]),
    .FP_INVALID(fp_raw[0]), .FP_TRAP_Q(fp_trap_q), .FP_ENV_Q(fp_env_q),
    .WB_VALID(wb_valid), .WB_EXEC_TRAP(wb_exec_trap), .WB_OPCODE(wb_opcode)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Comparison and closing.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d.", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // Access tasks; each request is held for exactly one taken edge.
  task automatic spr_wr(input logic [7:0] num, input fpx_word_t d);
    @(posedge clk_sys);
    spr_req   <= 1'b1;
    spr_write <= 1'b1;
    spr_num   <= num;
    spr_wdata <= d;
    @(posedge clk_sys);
    spr_req   <= 1'b0;
    #1;
    check({31'h0, spr_ack_q}, 32'h0000_0001);
  endtask

  task automatic spr_rd(input logic [7:0] num, output fpx_word_t d, output logic h);
    @(posedge clk_sys);
    spr_req   <= 1'b1;
    spr_write <= 1'b0;
    spr_num   <= num;
    @(posedge clk_sys);
    spr_req   <= 1'b0;
    #1;
    check({31'h0, spr_ack_q}, 32'h0000_0001);
    d = spr_rdata_q;
    h = spr_hit_q;
  endtask

  // Reads a mapped register and compares it; the caller's line holds the tag.
  task automatic rd_chk(input logic [7:0] num, input fpx_word_t exp);
    spr_rd(num, rd, hit);
    check({31'h0, hit}, 32'h0000_0001);
    check(rd, exp);
  endtask

  // Raw order: div, divisor zero, dividend finite, inexact, under, over, opnd, result, invalid.
  function automatic logic [8:0] rawof(input logic [5:0] c);
    return {c[5], c[5], c[5], c[4], c[3], c[2], c[1], 1'b0, c[0]};
  endfunction

  task automatic fp_op(input logic [8:0] raw, input logic exp_trap);
    @(posedge clk_sys);
    fp_valid <= 1'b1;
    fp_raw   <= raw;
    @(posedge clk_sys);
    fp_valid <= 1'b0;
    fp_raw   <= 9'h000;
    #1;
    check({31'h0, fp_trap_q}, {31'h0, exp_trap});
  endtask

  task automatic wb(input logic v, input logic t, input logic [7:0] op);
    @(posedge clk_sys);
    wb_valid     <= v;
    wb_exec_trap <= t;
    wb_opcode    <= op;
    @(posedge clk_sys);
    wb_valid     <= 1'b0;
    wb_exec_trap <= 1'b0;
  endtask

  // ==========================================================================
  // Watchdog; the whole sequence needs about 130 cycles.
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    fail_count = 0;
    tests_run = 0;
    rstn = 1'b0;
    ce = 1'b1;
    spr_req = 1'b0;
    spr_write = 1'b0;
    spr_num = 8'h00;
    spr_wdata = 32'h0000_0000;
    fp_valid = 1'b0;
    fp_raw = 9'h000;
    wb_valid = 1'b0;
    wb_exec_trap = 1'b0;
    wb_opcode = 8'h00;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reset contents, then the reserved environment bits.
    rd_chk(`FPX_SPR_ENV, 32'h0000_003f);
    rd_chk(`FPX_SPR_STAT, 32'h0000_0000);
    rd_chk(`FPX_SPR_OPC, 32'h0000_0000);
    spr_wr(`FPX_SPR_ENV, 32'hffff_ffff);
    rd_chk(`FPX_SPR_ENV, 32'h0000_01ff);
    check({23'h0, fp_env_q}, 32'h0000_01ff);
    // Software access, reserved positions and sticky clearing.
    spr_wr(`FPX_SPR_STAT, 32'hffff_ffff);
    rd_chk(`FPX_SPR_STAT, 32'h0000_3f3f);
    spr_wr(`FPX_SPR_STAT, 32'h0000_0000);
    rd_chk(`FPX_SPR_STAT, 32'h0000_0000);
    // All traps masked: no trap, sticky bits gather, trap-cause bits untouched.
    fp_op(rawof(6'h14), 1'b0);
    rd_chk(`FPX_SPR_STAT, 32'h0000_0014);
    fp_op(rawof(6'h08), 1'b0);
    rd_chk(`FPX_SPR_STAT, 32'h0000_001c);
    spr_wr(`FPX_SPR_STAT, 32'h0000_0000);
    // One cause at a time with only its mask open; each trap replaces the previous cause.
    for (int i = 0; i < 6; i++) begin
      spr_wr(`FPX_SPR_ENV, 32'h0000_003f ^ (32'h1 << i));
      check({23'h0, fp_env_q}, 32'h0000_003f ^ (32'h1 << i));
      fp_op(rawof(6'h01 << i), 1'b1);
      rd_chk(`FPX_SPR_STAT, 32'h0000_0100 << i);
    end
    // Unmasked overflow with masked inexact in the same operation.
    spr_wr(`FPX_SPR_ENV, 32'h0000_003b);
    fp_op(rawof(6'h14), 1'b1);
    rd_chk(`FPX_SPR_STAT, 32'h0000_1410);
    // Divide-by-zero needs a divide, a zero divisor and a finite non-zero dividend.
    spr_wr(`FPX_SPR_ENV, 32'h0000_001f);
    fp_op(9'b110_000000, 1'b0);
    fp_op(9'b011_000000, 1'b0);
    rd_chk(`FPX_SPR_STAT, 32'h0000_1410);
    // Reserved result alone raises the reserved-operand cause.
    spr_wr(`FPX_SPR_ENV, 32'h0000_003d);
    fp_op(9'b000_000010, 1'b1);
    rd_chk(`FPX_SPR_STAT, 32'h0000_0210);
    // Software write in the same cycle as a trap.
    spr_wr(`FPX_SPR_ENV, 32'h0000_003b);
    fork
      spr_wr(`FPX_SPR_STAT, 32'h0000_0100);
      fp_op(rawof(6'h14), 1'b1);
    join
    rd_chk(`FPX_SPR_STAT, 32'h0000_0110);
    // Clock enable low: an unmasked overflow with a masked underflow leaves no trace.
    @(posedge clk_sys);
    ce <= 1'b0;
    fp_op(rawof(6'h0c), 1'b0);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_chk(`FPX_SPR_STAT, 32'h0000_0110);
    // Opcode capture at write-back.
    wb(1'b1, 1'b1, 8'he5);
    rd_chk(`FPX_SPR_OPC, 32'h0000_00e5);
    wb(1'b1, 1'b0, 8'h12);
    wb(1'b0, 1'b1, 8'h33);
    rd_chk(`FPX_SPR_OPC, 32'h0000_00e5);
    wb(1'b1, 1'b1, 8'h3c);
    rd_chk(`FPX_SPR_OPC, 32'h0000_003c);
    spr_wr(`FPX_SPR_OPC, 32'hffff_ffff);
    rd_chk(`FPX_SPR_OPC, 32'h0000_00ff);
    // An unmapped number answers without a hit and with zero, not the last read data.
    spr_rd(8'h99, rd, hit);
    check({31'h0, hit}, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // A second reset in mid-run returns every register to its reset value.
    @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk(`FPX_SPR_ENV, 32'h0000_003f);
    check({23'h0, fp_env_q}, 32'h0000_003f);
    rd_chk(`FPX_SPR_STAT, 32'h0000_0000);
    rd_chk(`FPX_SPR_OPC, 32'h0000_0000);
    final_report();
  end
endmodule
